// file: common/rft_pkg.sv
// Constants and types shared by the frame timer unit
package rft_pkg;

	// Register map, byte offsets on the 8-bit register port
	localparam logic [7:0] ADDR_RX_MASK = 8'h0e;
	localparam logic [7:0] ADDR_NR_HIGH = 8'h0f;
	localparam logic [7:0] ADDR_NR_LOW  = 8'h10;
	localparam logic [7:0] ADDR_CTRL    = 8'h11;
	localparam logic [7:0] ADDR_GP_HIGH = 8'h12;
	localparam logic [7:0] ADDR_GP_LOW  = 8'h13;
	localparam logic [7:0] ADDR_STATUS  = 8'h18;

	// Default values
	localparam logic [7:0] RST_RX_MASK = 8'h08;
	localparam logic [7:0] RST_NR      = 8'h00;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_GP      = 8'h00;
	localparam logic [7:0] RST_ZERO    = 8'h00;

	// Control register fields
	localparam int         CTRL_STEP_BIT = 0;
	localparam int         CTRL_EMV_BIT  = 1;
	localparam int         CTRL_TRIG_LSB = 5;
	localparam logic [7:0] CTRL_WMASK    = 8'he3;

	// Status register fields
	localparam int STAT_MASK_BIT = 0;
	localparam int STAT_NR_BIT   = 1;
	localparam int STAT_GP_BIT   = 2;
	localparam int STAT_SQ_BIT   = 3;
	localparam int STAT_WAIT_BIT = 4;

	// Time steps in carrier periods
	localparam int STEP_MASK_FC     = 64;
	localparam int STEP_MASK_DIV    = 8;
	localparam int STEP_NR_FC       = 64;
	localparam int STEP_NR_LONG_FC  = 4096;
	localparam int STEP_GP_FC       = 8;
	localparam int MASK_MIN_STEPS   = 4;
	localparam int SQUELCH_DELAY_FC = MASK_MIN_STEPS * STEP_MASK_FC;

	// Step prescaler width and reload values
	localparam int         PRE_W       = 13;
	localparam logic [12:0] PRE_MASK   = 13'(STEP_MASK_FC - 1);
	localparam logic [12:0] PRE_MASK_P = 13'(STEP_MASK_FC * STEP_MASK_DIV - 1);
	localparam logic [12:0] PRE_NR     = 13'(STEP_NR_FC - 1);
	localparam logic [12:0] PRE_NR_L   = 13'(STEP_NR_LONG_FC - 1);
	localparam logic [12:0] PRE_GP     = 13'(STEP_GP_FC - 1);
	localparam logic [7:0]  MASK_MIN   = 8'(MASK_MIN_STEPS);
	localparam logic [8:0]  SQ_LAST    = 9'(SQUELCH_DELAY_FC - 1);

	// General purpose timer trigger codes
	localparam logic [2:0] TRIG_NONE       = 3'h0;
	localparam logic [2:0] TRIG_RX_END     = 3'h1;
	localparam logic [2:0] TRIG_RX_START   = 3'h2;
	localparam logic [2:0] TRIG_TX_END_NFC = 3'h3;

	// Timer slots
	localparam int T_MASK     = 0;
	localparam int T_NR       = 1;
	localparam int T_GP       = 2;
	localparam int NUM_TIMERS = 3;

	typedef enum logic [1:0] {
		RFT_NR_IDLE       = 2'b00,
		RFT_NR_WAIT_FIELD = 2'b01,
		RFT_NR_RUN        = 2'b10
	} rft_nr_state_type;

endpackage

// file: hdl/rft_down_counter.sv
// Down counter with step prescaler on carrier ticks
`timescale 1ns/1ns
`default_nettype none
module rft_down_counter #(
	parameter int W     = 16,
	parameter int PRE_W = 13
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             fc_tick,
	input  wire logic             load,
	input  wire logic             stop,
	input  wire logic [W-1:0]     value,
	input  wire logic [PRE_W-1:0] step_m1,
	output logic                  running,
	output logic                  expire
);

	logic [W-1:0]     count_q;
	logic [W-1:0]     count_d;
	logic [PRE_W-1:0] pre_q;
	logic [PRE_W-1:0] pre_d;
	logic             run_q;
	logic             run_d;
	logic             exp_q;
	logic             exp_d;
	logic [PRE_W-1:0] step_q;
	logic [PRE_W-1:0] step_d;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		count_d = count_q;
		pre_d   = pre_q;
		run_d   = run_q;
		exp_d   = 1'b0;
		step_d  = step_q;
		if (stop) begin
			run_d = 1'b0;
		end
		// Step rate latched at load so a mode change cannot stretch a step
		if (load && value != '0) begin
			count_d = value;
			pre_d   = step_m1;
			step_d  = step_m1;
			run_d   = 1'b1;
		end else if (run_q && !stop && fc_tick) begin
			if (pre_q == '0) begin
				pre_d = step_q;
				if (count_q == W'(1)) begin
					count_d = '0;
					run_d   = 1'b0;
					exp_d   = 1'b1;
				end else begin
					count_d = count_q - W'(1);
				end
			end else begin
				pre_d = pre_q - PRE_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= '0;
			pre_q   <= '0;
			step_q  <= '0;
			run_q   <= 1'b0;
			exp_q   <= 1'b0;
		end else begin
			count_q <= count_d;
			pre_q   <= pre_d;
			step_q  <= step_d;
			run_q   <= run_d;
			exp_q   <= exp_d;
		end
	end

	assign running = run_q;
	assign expire  = exp_q;

endmodule
`default_nettype wire

// file: hdl/rft_timers.sv
// Mask receive, no-response and general purpose frame timers
//
// What this block does
// (RL1) Receiver output is masked for a while after end of transmission.
// (RL2) Mask time is rx_mask_count times 64 carrier periods.
// (RL3) Counts zero to four give the minimum mask of four steps.
// (RL4) In bit rate detection mode one mask step is 512 periods.
// (RL5) For type A at 106 kbit/s the count means half FDT steps.
// (RL6) All registers take defaults at reset and on Set Default.
// (RL7) No-response timeout is 16 bits over two registers, step 64 periods.
// (RL8) noresp_step_sel picks 64 or 4096 carrier periods per step.
// (RL9) No-response timer runs from end of Tx, interrupts on expiry.
// (RL10) In NFC mode the timer starts only with an external field; the Start No-Response command starts it without one.
// (RL11) In active peer mode it starts when the transmitter turns off.
// (RL12) An all-zero no-response value never starts the timer.
// (RL13) Start No-Response command resets and restarts the timer.
// (RL14) noresp_emv_sel switches the no-response timer to EMV mode.
// (RL15) Trigger code zero: general timer starts only by command.
// (RL16) Code 001 starts at end of Rx, 010 at start of Rx.
// (RL17) Code 011 starts at end of Tx in NFC; expiry drops the field.
// (RL18) Auto squelch runs from 18.88 us after Tx to mask expiry.
// (RL19) General timer counts 16 bits in steps of 8 periods.
// (RL20) General timer expiry interrupt can be masked.
// (RL21) Trigger codes 100 to 111 act as 000; reserved bits read zero.
// (RL22) Timers reload on trigger, count down, expire once at zero.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module rft_timers #(
	parameter int NR_W = 16,
	parameter int GP_W = 16
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	input  wire logic       fc_tick,
	input  wire logic       cmd_set_default,
	input  wire logic       cmd_start_noresp,
	input  wire logic       cmd_start_gp,
	input  wire logic       tx_end,
	input  wire logic       tx_off,
	input  wire logic       rx_start,
	input  wire logic       rx_end,
	input  wire logic       ext_field,
	input  wire logic       mode_nfc,
	input  wire logic       mode_p2p_active,
	input  wire logic       mode_bitrate_detect,
	input  wire logic       squelch_auto_en,
	input  wire logic       gp_irq_mask,
	output logic            rx_mask,
	output logic            squelch_on,
	output logic            noresp_irq,
	output logic            gp_irq,
	output logic            field_off
);

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] rx_mask_time_q;
	logic [7:0] rx_mask_time_d;
	logic [7:0] nr_high_q;
	logic [7:0] nr_high_d;
	logic [7:0] nr_low_q;
	logic [7:0] nr_low_d;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] gp_high_q;
	logic [7:0] gp_high_d;
	logic [7:0] gp_low_q;
	logic [7:0] gp_low_d;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic [7:0] status;

	logic [NR_W-1:0] nr_value;
	logic [GP_W-1:0] gp_value;
	logic [2:0]      trig_sel;
	logic            nr_step_long;
	logic            nr_emv;

	// (RL7) High byte over low byte
	assign nr_value     = NR_W'({nr_high_q, nr_low_q});
	// (RL19) Sixteen bit general timeout
	assign gp_value     = GP_W'({gp_high_q, gp_low_q});
	assign trig_sel     = ctrl_q[rft_pkg::CTRL_TRIG_LSB +: 3];
	assign nr_step_long = ctrl_q[rft_pkg::CTRL_STEP_BIT];
	assign nr_emv       = ctrl_q[rft_pkg::CTRL_EMV_BIT];

	always_comb begin
		rx_mask_time_d = rx_mask_time_q;
		nr_high_d      = nr_high_q;
		nr_low_d       = nr_low_q;
		ctrl_d         = ctrl_q;
		gp_high_d      = gp_high_q;
		gp_low_d       = gp_low_q;
		// (RL6) Set Default wins over a write
		if (cmd_set_default) begin
			rx_mask_time_d = rft_pkg::RST_RX_MASK;
			nr_high_d      = rft_pkg::RST_NR;
			nr_low_d       = rft_pkg::RST_NR;
			ctrl_d         = rft_pkg::RST_CTRL;
			gp_high_d      = rft_pkg::RST_GP;
			gp_low_d       = rft_pkg::RST_GP;
		end else if (wr_en) begin
			case (addr)
				rft_pkg::ADDR_RX_MASK: rx_mask_time_d = wr_data;
				rft_pkg::ADDR_NR_HIGH: nr_high_d      = wr_data;
				rft_pkg::ADDR_NR_LOW:  nr_low_d       = wr_data;
				// (RL21) Reserved bits dropped
				rft_pkg::ADDR_CTRL:
					ctrl_d = wr_data & rft_pkg::CTRL_WMASK;
				rft_pkg::ADDR_GP_HIGH: gp_high_d      = wr_data;
				rft_pkg::ADDR_GP_LOW:  gp_low_d       = wr_data;
				default:               ctrl_d         = ctrl_q;
			endcase
		end
	end

	// Unmapped reads return zero rather than hold the bus
	always_comb begin
		rd_data_d = rft_pkg::RST_ZERO;
		if (rd_en) begin
			case (addr)
				rft_pkg::ADDR_RX_MASK: rd_data_d = rx_mask_time_q;
				rft_pkg::ADDR_NR_HIGH: rd_data_d = nr_high_q;
				rft_pkg::ADDR_NR_LOW:  rd_data_d = nr_low_q;
				rft_pkg::ADDR_CTRL:    rd_data_d = ctrl_q;
				rft_pkg::ADDR_GP_HIGH: rd_data_d = gp_high_q;
				rft_pkg::ADDR_GP_LOW:  rd_data_d = gp_low_q;
				rft_pkg::ADDR_STATUS:  rd_data_d = status;
				default:               rd_data_d = rft_pkg::RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		// (RL6) Power-up defaults
		if (rst) begin
			rx_mask_time_q <= rft_pkg::RST_RX_MASK;
			nr_high_q      <= rft_pkg::RST_NR;
			nr_low_q       <= rft_pkg::RST_NR;
			ctrl_q         <= rft_pkg::RST_CTRL;
			gp_high_q      <= rft_pkg::RST_GP;
			gp_low_q       <= rft_pkg::RST_GP;
			rd_data_q      <= rft_pkg::RST_ZERO;
		end else begin
			rx_mask_time_q <= rx_mask_time_d;
			nr_high_q      <= nr_high_d;
			nr_low_q       <= nr_low_d;
			ctrl_q         <= ctrl_d;
			gp_high_q      <= gp_high_d;
			gp_low_q       <= gp_low_d;
			rd_data_q      <= rd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer slots

	logic [15:0]              load_val  [rft_pkg::NUM_TIMERS];
	logic [rft_pkg::PRE_W-1:0] step_m1  [rft_pkg::NUM_TIMERS];
	logic [rft_pkg::NUM_TIMERS-1:0] load_v;
	logic [rft_pkg::NUM_TIMERS-1:0] stop_v;
	logic [rft_pkg::NUM_TIMERS-1:0] run_v;
	logic [rft_pkg::NUM_TIMERS-1:0] exp_v;
	logic [7:0]               mask_count;

	// (RL22) One shared down counter shape for all three timers
	genvar gi;
	generate
		for (gi = 0; gi < rft_pkg::NUM_TIMERS; gi++) begin : g_tmr
			rft_down_counter #(
				.W     (16),
				.PRE_W (rft_pkg::PRE_W)
			) u_cnt (
				.clk     (clk),
				.rst     (rst),
				.fc_tick (fc_tick),
				.load    (load_v[gi]),
				.stop    (stop_v[gi]),
				.value   (load_val[gi]),
				.step_m1 (step_m1[gi]),
				.running (run_v[gi]),
				.expire  (exp_v[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Mask receive timer

	// (RL3) Floor at four steps
	assign mask_count = (rx_mask_time_q < rft_pkg::MASK_MIN) ?
		rft_pkg::MASK_MIN : rx_mask_time_q;

	// (RL1) Starts at every end of transmission
	assign load_v[rft_pkg::T_MASK]   = tx_end;
	assign stop_v[rft_pkg::T_MASK]   = 1'b0;
	// (RL5) Half FDT steps equal 64 periods, so no extra scaling
	assign load_val[rft_pkg::T_MASK] = {8'h00, mask_count};
	// (RL2) (RL4) Step of 64, or 512 in bit rate detection
	assign step_m1[rft_pkg::T_MASK]  = mode_bitrate_detect ?
		rft_pkg::PRE_MASK_P : rft_pkg::PRE_MASK;
	assign rx_mask = run_v[rft_pkg::T_MASK];

	////////////////////////////////////////////////////////////////////////
	// Squelch window

	logic [8:0] sq_cnt_q;
	logic [8:0] sq_cnt_d;
	logic       sq_done_q;
	logic       sq_done_d;
	logic       sq_on_q;
	logic       sq_on_d;

	// Delay counted in carrier ticks, independent of the mask step size
	always_comb begin
		sq_cnt_d  = sq_cnt_q;
		sq_done_d = sq_done_q;
		if (tx_end) begin
			sq_cnt_d  = '0;
			sq_done_d = 1'b0;
		end else if (run_v[rft_pkg::T_MASK] && !sq_done_q && fc_tick) begin
			if (sq_cnt_q == rft_pkg::SQ_LAST) begin
				sq_done_d = 1'b1;
			end else begin
				sq_cnt_d = sq_cnt_q + 9'h001;
			end
		end
		// (RL18) On after delay, off at mask expiry
		// Registered done flag: a minimum mask of 64-period steps ends before squelch starts
		sq_on_d = squelch_auto_en && sq_done_q && run_v[rft_pkg::T_MASK]
			&& !exp_v[rft_pkg::T_MASK] && !tx_end;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sq_cnt_q  <= 9'h000;
			sq_done_q <= 1'b0;
			sq_on_q   <= 1'b0;
		end else begin
			sq_cnt_q  <= sq_cnt_d;
			sq_done_q <= sq_done_d;
			sq_on_q   <= sq_on_d;
		end
	end

	assign squelch_on = sq_on_q;

	////////////////////////////////////////////////////////////////////////
	// No-response timer control

	rft_pkg::rft_nr_state_type nr_state_q;
	rft_pkg::rft_nr_state_type nr_state_d;
	logic nr_auto;
	logic nr_load;
	logic nr_stop;
	logic nr_irq_q;
	logic nr_irq_d;

	// (RL9) (RL11) End of Tx, or transmitter off in active peer mode
	assign nr_auto = mode_p2p_active ? tx_off : tx_end;

	always_comb begin
		nr_state_d = nr_state_q;
		nr_load    = 1'b0;
		nr_stop    = 1'b0;
		// (RL12) Zero value never arms or starts
		if (nr_value == '0) begin
			if (cmd_start_noresp || nr_auto) begin
				nr_stop    = 1'b1;
				nr_state_d = rft_pkg::RFT_NR_IDLE;
			end
		// (RL13) Command restarts at once
		end else if (cmd_start_noresp) begin
			nr_load    = 1'b1;
			nr_state_d = rft_pkg::RFT_NR_RUN;
		// (RL10) NFC mode waits for an external field
		end else if (nr_auto && mode_nfc && !ext_field) begin
			nr_stop    = 1'b1;
			nr_state_d = rft_pkg::RFT_NR_WAIT_FIELD;
		end else if (nr_auto) begin
			nr_load    = 1'b1;
			nr_state_d = rft_pkg::RFT_NR_RUN;
		end else begin
			case (nr_state_q)
				rft_pkg::RFT_NR_IDLE: begin
					nr_state_d = rft_pkg::RFT_NR_IDLE;
				end
				rft_pkg::RFT_NR_WAIT_FIELD: begin
					if (ext_field) begin
						nr_load    = 1'b1;
						nr_state_d = rft_pkg::RFT_NR_RUN;
					end
				end
				rft_pkg::RFT_NR_RUN: begin
					if (exp_v[rft_pkg::T_NR]) begin
						nr_state_d = rft_pkg::RFT_NR_IDLE;
					// (RL14) EMV mode keeps running through a response
					end else if (rx_start && !nr_emv) begin
						nr_stop    = 1'b1;
						nr_state_d = rft_pkg::RFT_NR_IDLE;
					end
				end
				default: begin
					nr_state_d = rft_pkg::RFT_NR_IDLE;
				end
			endcase
		end
		// (RL9) Expiry without response
		nr_irq_d = exp_v[rft_pkg::T_NR];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			nr_state_q <= rft_pkg::RFT_NR_IDLE;
			nr_irq_q   <= 1'b0;
		end else begin
			nr_state_q <= nr_state_d;
			nr_irq_q   <= nr_irq_d;
		end
	end

	assign load_v[rft_pkg::T_NR]   = nr_load;
	assign stop_v[rft_pkg::T_NR]   = nr_stop;
	assign load_val[rft_pkg::T_NR] = 16'(nr_value);
	// (RL8) Step select
	assign step_m1[rft_pkg::T_NR]  = nr_step_long ?
		rft_pkg::PRE_NR_L : rft_pkg::PRE_NR;
	assign noresp_irq = nr_irq_q;

	////////////////////////////////////////////////////////////////////////
	// General purpose timer

	logic gp_trig;
	logic gp_fo_arm_q;
	logic gp_fo_arm_d;
	logic gp_irq_q;
	logic gp_irq_d;
	logic field_off_q;
	logic field_off_d;

	always_comb begin
		case (trig_sel)
			// (RL16) Rx edges
			rft_pkg::TRIG_RX_END:     gp_trig = rx_end;
			rft_pkg::TRIG_RX_START:   gp_trig = rx_start;
			// (RL17) End of Tx in NFC mode
			rft_pkg::TRIG_TX_END_NFC: gp_trig = tx_end && mode_nfc;
			// (RL15) (RL21) None, and unused codes
			default:                  gp_trig = 1'b0;
		endcase
		gp_fo_arm_d = gp_fo_arm_q;
		if (cmd_start_gp || gp_trig) begin
			gp_fo_arm_d = !cmd_start_gp &&
				trig_sel == rft_pkg::TRIG_TX_END_NFC;
		end else if (exp_v[rft_pkg::T_GP]) begin
			gp_fo_arm_d = 1'b0;
		end
		// (RL20) Mask gates the interrupt only
		gp_irq_d    = exp_v[rft_pkg::T_GP] && !gp_irq_mask;
		// (RL17) Field off at expiry
		field_off_d = exp_v[rft_pkg::T_GP] && gp_fo_arm_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gp_fo_arm_q <= 1'b0;
			gp_irq_q    <= 1'b0;
			field_off_q <= 1'b0;
		end else begin
			gp_fo_arm_q <= gp_fo_arm_d;
			gp_irq_q    <= gp_irq_d;
			field_off_q <= field_off_d;
		end
	end

	assign load_v[rft_pkg::T_GP]   = cmd_start_gp || gp_trig;
	assign stop_v[rft_pkg::T_GP]   = 1'b0;
	assign load_val[rft_pkg::T_GP] = 16'(gp_value);
	// (RL19) Eight period step
	assign step_m1[rft_pkg::T_GP]  = rft_pkg::PRE_GP;
	assign gp_irq    = gp_irq_q;
	assign field_off = field_off_q;

	////////////////////////////////////////////////////////////////////////
	// Status

	always_comb begin
		status = rft_pkg::RST_ZERO;
		status[rft_pkg::STAT_MASK_BIT] = run_v[rft_pkg::T_MASK];
		status[rft_pkg::STAT_NR_BIT]   = run_v[rft_pkg::T_NR];
		status[rft_pkg::STAT_GP_BIT]   = run_v[rft_pkg::T_GP];
		status[rft_pkg::STAT_SQ_BIT]   = sq_on_q;
		status[rft_pkg::STAT_WAIT_BIT] =
			nr_state_q == rft_pkg::RFT_NR_WAIT_FIELD;
	end

	assign rd_data = rd_data_q;

endmodule
`default_nettype wire

// file: sim/rft_timers_checker.sv
// Port checks for the frame timer unit
`timescale 1ns/1ns
`default_nettype none
module rft_timers_checker (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic       rd_en,
	input wire logic [7:0] rd_data,
	input wire logic       fc_tick,
	input wire logic       tx_end,
	input wire logic       gp_irq_mask,
	input wire logic       rx_mask,
	input wire logic       squelch_on,
	input wire logic       noresp_irq,
	input wire logic       gp_irq,
	input wire logic       field_off
);
	logic [15:0] tick_q;
	logic [15:0] tick_d;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////
	// Carrier ticks seen while masked; saturates on long runs
	always_comb begin
		tick_d = tick_q;
		if (tx_end)
			tick_d = 16'h0000;
		else if (rx_mask && fc_tick && tick_q != 16'hffff)
			tick_d = tick_q + 16'h0001;
	end
	always_ff @(posedge clk) begin
		if (rst)
			tick_q <= 16'h0000;
		else
			tick_q <= tick_d;
	end

	////////////////////////////////////////////////////////////
	a_mask_start: assert property (tx_end |=> rx_mask)
		else $error("mask not raised after end of transmission");
	a_mask_min: assert property ($fell(rx_mask) |-> tick_q >= 16'd255)
		else $error("mask shorter than four steps");
	a_squelch_late: assert property ($rose(squelch_on) |->
		rx_mask && tick_q >= 16'd250)
		else $error("squelch started too early");
	a_squelch_end: assert property (!rx_mask [*2] |-> !squelch_on)
		else $error("squelch still on after mask ended");
	a_nr_pulse: assert property (noresp_irq |=> !noresp_irq)
		else $error("no-response interrupt longer than one cycle");
	a_field_pulse: assert property (field_off |=> !field_off)
		else $error("field off request longer than one cycle");
	a_gp_masked: assert property (
		gp_irq_mask && $past(gp_irq_mask) |-> !gp_irq)
		else $error("general timer interrupt not suppressed");
	a_ctrl_resv: assert property (
		$past(rd_en) && $past(addr) == rft_pkg::ADDR_CTRL
		|-> rd_data[4:2] == 3'h0)
		else $error("reserved control bits read nonzero");
	a_reset_quiet: assert property ($fell(rst) |->
		!rx_mask && !noresp_irq && !gp_irq && !field_off)
		else $error("outputs active after reset");

	c_mask_end: cover property ($fell(rx_mask));
	c_nr_irq: cover property (noresp_irq);
	c_gp_irq: cover property (gp_irq);
	c_field: cover property (field_off);
endmodule

bind rft_timers rft_timers_checker u_chk (.clk, .rst, .addr, .rd_en,
	.rd_data, .fc_tick, .tx_end, .gp_irq_mask, .rx_mask, .squelch_on,
	.noresp_irq, .gp_irq, .field_off);
`default_nettype wire

// file: sim/rft_timers_test.sv
// Register and timer sequences for the frame timer unit
`timescale 1ns/1ns
`default_nettype none
module rft_timers_test;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [6:0] ev = 7'h00;
	logic       ext_field = 1'b0;
	logic       mode_nfc = 1'b0;
	logic       mode_p2p = 1'b0;
	logic       mode_brd = 1'b0;
	logic       sq_en = 1'b1;
	logic       gp_mask = 1'b0;
	logic       fc_tick = 1'b1;
	logic [7:0] rd_data;
	logic       rx_mask;
	logic       squelch_on;
	logic       noresp_irq;
	logic       gp_irq;
	logic       field_off;
	int         err_total = 0;
	int         compares = 0;
	int         gp_seen = 0;
	int         fo_seen = 0;
	int         n;
	int         mc[4] = '{0, 4, 5, 8};

	// Event pulses: 0 tx end, 1 tx off, 2 rx start, 3 rx end,
	// 4 start no-response, 5 start general timer, 6 set default
	rft_timers dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fc_tick(fc_tick),
		.cmd_set_default(ev[6]), .cmd_start_noresp(ev[4]),
		.cmd_start_gp(ev[5]), .tx_end(ev[0]), .tx_off(ev[1]),
		.rx_start(ev[2]), .rx_end(ev[3]), .ext_field(ext_field),
		.mode_nfc(mode_nfc), .mode_p2p_active(mode_p2p),
		.mode_bitrate_detect(mode_brd), .squelch_auto_en(sq_en),
		.gp_irq_mask(gp_mask), .rx_mask(rx_mask), .squelch_on(squelch_on),
		.noresp_irq(noresp_irq), .gp_irq(gp_irq), .field_off(field_off));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (gp_irq === 1'b1)
			gp_seen <= gp_seen + 1;
		if (field_off === 1'b1)
			fo_seen <= fo_seen + 1;
	end

	////////////////////////////////////////////////////////////
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("CHECK FAILED at %0t: count %0d not in %0d..%0d",
				$time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk_val(rd_data, exp);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		#1;
	endtask
	// Cycles to the no-response interrupt, 0 if none in time
	task automatic wait_irq(output int k);
		k = 0;
		for (int i = 1; i <= 4300 && k == 0; i++) begin
			@(posedge clk);
			#1;
			if (noresp_irq === 1'b1)
				k = i;
		end
	endtask
	task automatic nr_run(input int i, input int lo, input int hi);
		pulse(i);
		wait_irq(n);
		chk_rng(n, lo, hi);
	endtask
	task automatic mask_run(input int ns);
		int m;
		int s;
		m = 0;
		s = 0;
		pulse(0);
		for (int i = 0; i < 5000 && (i < 3 || rx_mask); i++) begin
			if (rx_mask === 1'b1)
				m++;
			if (squelch_on === 1'b1)
				s++;
			@(posedge clk);
			#1;
		end
		chk_rng(m, ns, ns);
		// Squelch starts 256 periods in, so short masks may show none
		chk_rng(s, ns > 257 ? ns - 260 : 0, ns > 257 ? ns - 254 : 3);
	endtask
	task automatic gp_try(input int i, input int g, input int f);
		gp_seen = 0;
		fo_seen = 0;
		pulse(i);
		repeat (40) @(posedge clk);
		#1;
		chk_rng(gp_seen, g, g);
		chk_rng(fo_seen, f, f);
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0e, 8'h08);
		rd_chk(8'h11, 8'h00);
		rd_chk(8'h20, 8'h00);
		wr(8'h11, 8'hff);
		rd_chk(8'h11, 8'he3);
		wr(8'h0e, 8'h33);
		wr(8'h0f, 8'h12);
		wr(8'h10, 8'h34);
		rd_chk(8'h0f, 8'h12);
		rd_chk(8'h10, 8'h34);
		pulse(6);
		rd_chk(8'h0e, 8'h08);
		rd_chk(8'h0f, 8'h00);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h11, 8'h00);
		$display("test registers done");
		foreach (mc[i]) begin
			wr(8'h0e, 8'(mc[i]));
			mask_run((mc[i] < 4 ? 4 : mc[i]) * 64);
		end
		@(posedge clk) mode_brd <= 1'b1;
		wr(8'h0e, 8'h05);
		mask_run(2560);
		@(posedge clk) mode_brd <= 1'b0;
		$display("test mask done");
		nr_run(4, 0, 0);
		wr(8'h10, 8'h03);
		nr_run(0, 193, 195);
		wr(8'h11, 8'h01);
		wr(8'h10, 8'h01);
		nr_run(4, 4097, 4099);
		wr(8'h11, 8'h00);
		wr(8'h10, 8'h03);
		pulse(4);
		repeat (100) @(posedge clk);
		nr_run(4, 193, 195);
		pulse(0);
		repeat (50) @(posedge clk);
		nr_run(2, 0, 0);
		wr(8'h11, 8'h02);
		pulse(0);
		repeat (50) @(posedge clk);
		nr_run(2, 140, 144);
		wr(8'h11, 8'h00);
		@(posedge clk) mode_p2p <= 1'b1;
		nr_run(0, 0, 0);
		nr_run(1, 193, 195);
		@(posedge clk) mode_p2p <= 1'b0;
		mode_nfc <= 1'b1;
		nr_run(0, 0, 0);
		rd_chk(8'h18, 8'h10);
		@(posedge clk) ext_field <= 1'b1;
		wait_irq(n);
		chk_rng(n, 193, 198);
		$display("test no-response done");
		wr(8'h10, 8'h00);
		wr(8'h13, 8'h02);
		for (int c = 0; c < 8; c++) begin
			wr(8'h11, 8'(c << 5));
			gp_try(3, c == 1, 0);
			gp_try(2, c == 2, 0);
			gp_try(0, c == 3, c == 3);
		end
		wr(8'h11, 8'h00);
		gp_try(5, 1, 0);
		@(posedge clk) gp_mask <= 1'b1;
		gp_try(5, 0, 0);
		$display("test general timer done");
		complete_run;
	end

	initial begin
		#1000000;
		err_total++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		complete_run;
	end
endmodule
`default_nettype wire
